// [inc/fbpp_defs.vh]
// Constants for the frame buffer pixel packer: formats, orders, widths, colour factors
`ifndef FBPP_DEFS_VH
`define FBPP_DEFS_VH

// Pixel format codes
`define FBPP_FMT_ARGB8888      3'h0
`define FBPP_FMT_RGB888        3'h1
`define FBPP_FMT_RGB565        3'h2
`define FBPP_FMT_ARGB1555      3'h3
`define FBPP_FMT_ARGB4444      3'h4
`define FBPP_FMT_GRAY_FOUR_BIT 3'h5
`define FBPP_FMT_GRAY_TWO_BIT  3'h6
`define FBPP_FMT_GRAY_ONE_BIT  3'h7

// In-byte packing order and buffer scan order codes
`define FBPP_PACK_LINE   1'b0
`define FBPP_PACK_COLUMN 1'b1
`define FBPP_SCAN_ROW    1'b0
`define FBPP_SCAN_COLUMN 1'b1

// Datapath widths
`define FBPP_COORD_W  11
`define FBPP_STRIDE_W 14
`define FBPP_ADDR_W   24

// Luminance weights, summing to 256
`define FBPP_LUMA_R 8'h4d
`define FBPP_LUMA_G 8'h96
`define FBPP_LUMA_B 8'h1d

// Gray quantisation divisors and read-back replication factors
`define FBPP_DIV_FOUR_BIT 8'h11
`define FBPP_DIV_TWO_BIT  8'h55
`define FBPP_DIV_ONE_BIT  8'hff
`define FBPP_REP_FOUR_BIT 24'h11_1111
`define FBPP_REP_TWO_BIT  24'h55_5555
`define FBPP_REP_ONE_BIT  24'hff_ffff
`define FBPP_OPAQUE       8'hff

`endif

// [verilog/fbpp_luma.v]
// Two-stage luminance reduction of a 32-bit colour to an 8-bit gray level
`include "fbpp_defs.vh"

module fbpp_luma (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire [31:0] argb,
    output reg  [7:0]  gray_q
);

    reg  [15:0] red_q;
    reg  [15:0] green_q;
    reg  [15:0] blue_q;
    wire [16:0] sum_w;

    // Stage one: weighted products of each component
    always @(posedge ref_clk) begin
        if (rst) begin
            red_q   <= 16'h0000;
            green_q <= 16'h0000;
            blue_q  <= 16'h0000;
        end else begin
            red_q   <= {8'h00, argb[23:16]} * {8'h00, `FBPP_LUMA_R};
            green_q <= {8'h00, argb[15:8]} * {8'h00, `FBPP_LUMA_G};
            blue_q  <= {8'h00, argb[7:0]} * {8'h00, `FBPP_LUMA_B};
        end
    end

    // Stage two: sum never exceeds 0xff00, so the top byte is the level
    assign sum_w = {1'b0, red_q} + {1'b0, green_q} + {1'b0, blue_q};

    always @(posedge ref_clk) begin
        if (rst) begin
            gray_q <= 8'h00;
        end else begin
            gray_q <= sum_w[15:8];
        end
    end

endmodule

// [verilog/fbpp_packer.v]
// Frame buffer pixel packer: pixel address, bit placement and colour conversion
`include "fbpp_defs.vh"

module fbpp_packer (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire [2:0]  pixel_format,
    input  wire        in_byte_packing_order,
    input  wire        buffer_scan_order,
    input  wire [10:0] frame_width,
    input  wire [10:0] frame_height,
    input  wire        req_valid,
    input  wire        req_read,
    input  wire [10:0] req_x,
    input  wire [10:0] req_y,
    input  wire [31:0] req_argb,
    output reg         mem_wr_q,
    output reg         mem_rd_q,
    output reg  [23:0] mem_addr_q,
    output reg  [31:0] mem_wdata_q,
    output reg  [3:0]  mem_byte_en_q,
    output reg  [7:0]  mem_bit_mask_q,
    input  wire        dec_valid,
    input  wire [10:0] dec_x,
    input  wire [10:0] dec_y,
    input  wire [31:0] dec_data,
    output reg         dec_argb_valid_q,
    output reg  [31:0] dec_argb_q
);

    // Sub-byte formats: log2 of pixels per byte; zero for byte-wide formats
    // Drives both the address shifts and the rounding term
    function [1:0] fbpp_shift_f;
        input [2:0] fmt;
        begin
            case (fmt)
                `FBPP_FMT_GRAY_FOUR_BIT: fbpp_shift_f = 2'd1;
                `FBPP_FMT_GRAY_TWO_BIT:  fbpp_shift_f = 2'd2;
                `FBPP_FMT_GRAY_ONE_BIT:  fbpp_shift_f = 2'd3;
                default:                 fbpp_shift_f = 2'd0;
            endcase
        end
    endfunction

    // Bit position of a sub-byte pixel inside its byte, lowest index at LSB
    // Line packing ranks pixels by x, column packing by y
    function [2:0] fbpp_bit_pos_f;
        input [10:0] x;
        input [10:0] y;
        input        order;
        input [2:0]  fmt;
        reg   [10:0] c;
        begin
            c = (order == `FBPP_PACK_COLUMN) ? y : x;
            case (fmt)
                `FBPP_FMT_GRAY_FOUR_BIT: fbpp_bit_pos_f = {c[0], 2'b00};
                `FBPP_FMT_GRAY_TWO_BIT:  fbpp_bit_pos_f = {c[1:0], 1'b0};
                `FBPP_FMT_GRAY_ONE_BIT:  fbpp_bit_pos_f = c[2:0];
                default:                 fbpp_bit_pos_f = 3'd0;
            endcase
        end
    endfunction

    // Stage one registers
    reg         s1_valid_q;
    reg         s1_read_q;
    reg  [2:0]  s1_fmt_q;
    reg         s1_order_q;
    reg  [31:0] s1_argb_q;
    reg  [10:0] s1_major_q;
    reg  [13:0] s1_stride_q;
    reg  [13:0] s1_minor_q;
    reg  [2:0]  s1_pos_q;

    // Stage two registers
    reg         s2_valid_q;
    reg         s2_read_q;
    reg  [2:0]  s2_fmt_q;
    reg  [31:0] s2_argb_q;
    reg  [23:0] s2_addr_q;
    reg  [2:0]  s2_pos_q;

    // Stage one next values
    reg  [1:0]  shift_d;
    reg  [2:0]  bytes_d;
    reg  [13:0] round_d;
    reg  [10:0] major_d;
    reg  [13:0] stride_d;
    reg  [13:0] minor_d;

    wire [7:0]  gray_w;
    wire [24:0] prod_w;
    wire [24:0] addr_w;

    // Gray level runs beside the address path and lands in stage two
    fbpp_luma u_luma (
        .ref_clk (ref_clk),
        .rst     (rst),
        .argb    (req_argb),
        .gray_q  (gray_w)
    );

    // Choose major coordinate, byte stride and minor offset per scan and packing
    // Byte address is major * stride + minor; ppb is pixels per byte
    //   row scan, line packing:      y * padded row bytes + x / ppb
    //   row scan, column packing:    (y / ppb) * width + x
    //   column scan, line packing:   (x / ppb) * height + y
    //   column scan, column packing: x * padded column bytes + y / ppb
    // Coordinates are not clamped: pixels outside the frame alias elsewhere
    always @* begin
        shift_d  = fbpp_shift_f(pixel_format);
        bytes_d  = 3'd2;
        round_d  = 14'h0000;
        major_d  = req_y;
        stride_d = 14'h0000;
        minor_d  = 14'h0000;
        case (pixel_format)
            `FBPP_FMT_ARGB8888: bytes_d = 3'd4;
            `FBPP_FMT_RGB888:   bytes_d = 3'd3;
            default:            bytes_d = 3'd2;
        endcase
        // Rounding term pads a partial byte at a row or column end
        case (shift_d)
            2'd1:    round_d = 14'h0001;
            2'd2:    round_d = 14'h0003;
            2'd3:    round_d = 14'h0007;
            default: round_d = 14'h0000;
        endcase
        if (shift_d == 2'd0) begin
            // Byte-wide pixels: row by row, left to right, top row first
            major_d  = req_y;
            stride_d = {3'b000, frame_width} * {11'h000, bytes_d};
            minor_d  = {3'b000, req_x} * {11'h000, bytes_d};
        end else begin
            case ({buffer_scan_order, in_byte_packing_order})
                {`FBPP_SCAN_ROW, `FBPP_PACK_LINE}: begin
                    // Row padded to whole bytes, bytes step along the row
                    major_d  = req_y;
                    stride_d = ({3'b000, frame_width} + round_d) >> shift_d;
                    minor_d  = {3'b000, req_x} >> shift_d;
                end
                {`FBPP_SCAN_ROW, `FBPP_PACK_COLUMN}: begin
                    // One byte per column of a row group, bytes step in x
                    major_d  = req_y >> shift_d;
                    stride_d = {3'b000, frame_width};
                    minor_d  = {3'b000, req_x};
                end
                {`FBPP_SCAN_COLUMN, `FBPP_PACK_LINE}: begin
                    // One byte per row of a column group, bytes step in y
                    major_d  = req_x >> shift_d;
                    stride_d = {3'b000, frame_height};
                    minor_d  = {3'b000, req_y};
                end
                default: begin
                    // Column padded to whole bytes, bytes step down the column
                    major_d  = req_x;
                    stride_d = ({3'b000, frame_height} + round_d) >> shift_d;
                    minor_d  = {3'b000, req_y} >> shift_d;
                end
            endcase
        end
    end

    // Stage one: capture request, configuration and address terms
    // Configuration travels with each pixel, so a change only affects later ones
    always @(posedge ref_clk) begin
        if (rst) begin
            s1_valid_q  <= 1'b0;
            s1_read_q   <= 1'b0;
            s1_fmt_q    <= `FBPP_FMT_ARGB8888;
            s1_order_q  <= `FBPP_PACK_LINE;
            s1_argb_q   <= 32'h0000_0000;
            s1_major_q  <= 11'h000;
            s1_stride_q <= 14'h0000;
            s1_minor_q  <= 14'h0000;
            s1_pos_q    <= 3'd0;
        end else begin
            s1_valid_q  <= req_valid;
            s1_read_q   <= req_read;
            s1_fmt_q    <= pixel_format;
            s1_order_q  <= in_byte_packing_order;
            s1_argb_q   <= req_argb;
            s1_major_q  <= major_d;
            s1_stride_q <= stride_d;
            s1_minor_q  <= minor_d;
            s1_pos_q    <= fbpp_bit_pos_f(req_x, req_y, in_byte_packing_order,
                                          pixel_format);
        end
    end

    // Byte address of the pixel's lowest byte
    // Top product bit is dropped on purpose: the address wraps at 24 bits
    assign prod_w = {14'h0000, s1_major_q} * {11'h000, s1_stride_q};
    assign addr_w = prod_w + {11'h000, s1_minor_q};

    // Stage two: address formed, luminance arrives alongside
    // Luminance has the same two-cycle delay, so gray_w matches stage two
    always @(posedge ref_clk) begin
        if (rst) begin
            s2_valid_q <= 1'b0;
            s2_read_q  <= 1'b0;
            s2_fmt_q   <= `FBPP_FMT_ARGB8888;
            s2_argb_q  <= 32'h0000_0000;
            s2_addr_q  <= 24'h00_0000;
            s2_pos_q   <= 3'd0;
        end else begin
            s2_valid_q <= s1_valid_q;
            s2_read_q  <= s1_read_q;
            s2_fmt_q   <= s1_fmt_q;
            s2_argb_q  <= s1_argb_q;
            s2_addr_q  <= addr_w[23:0];
            s2_pos_q   <= s1_pos_q;
        end
    end

    // Colour encoding into the stored pixel format
    // Gray codes truncate: a level just below a step rounds down
    reg [31:0] wdata_d;
    reg [3:0]  byte_en_d;
    reg [7:0]  bit_mask_d;
    reg [7:0]  code_d;

    always @* begin
        wdata_d    = 32'h0000_0000;
        byte_en_d  = 4'h3;
        bit_mask_d = 8'hff;
        code_d     = 8'h00;
        case (s2_fmt_q)
            `FBPP_FMT_ARGB8888: begin
                wdata_d   = s2_argb_q;
                byte_en_d = 4'hf;
            end
            `FBPP_FMT_RGB888: begin
                wdata_d   = {8'h00, s2_argb_q[23:0]};
                byte_en_d = 4'h7;
            end
            `FBPP_FMT_RGB565: begin
                wdata_d = {16'h0000, s2_argb_q[23:19], s2_argb_q[15:10],
                           s2_argb_q[7:3]};
            end
            `FBPP_FMT_ARGB1555: begin
                wdata_d = {16'h0000, s2_argb_q[31], s2_argb_q[23:19],
                           s2_argb_q[15:11], s2_argb_q[7:3]};
            end
            `FBPP_FMT_ARGB4444: begin
                wdata_d = {16'h0000, s2_argb_q[31:28], s2_argb_q[23:20],
                           s2_argb_q[15:12], s2_argb_q[7:4]};
            end
            `FBPP_FMT_GRAY_FOUR_BIT: begin
                code_d     = gray_w / `FBPP_DIV_FOUR_BIT;
                wdata_d    = {24'h00_0000, code_d << s2_pos_q};
                byte_en_d  = 4'h1;
                bit_mask_d = 8'h0f << s2_pos_q;
            end
            `FBPP_FMT_GRAY_TWO_BIT: begin
                code_d     = gray_w / `FBPP_DIV_TWO_BIT;
                wdata_d    = {24'h00_0000, code_d << s2_pos_q};
                byte_en_d  = 4'h1;
                bit_mask_d = 8'h03 << s2_pos_q;
            end
            default: begin
                code_d     = gray_w / `FBPP_DIV_ONE_BIT;
                wdata_d    = {24'h00_0000, code_d << s2_pos_q};
                byte_en_d  = 4'h1;
                bit_mask_d = 8'h01 << s2_pos_q;
            end
        endcase
    end

    // Stage three: memory access outputs; reads carry address, lanes and mask with zero data
    // Sub-byte writes only touch lane zero; memory must merge under the bit mask
    // Data, lanes and mask return to zero between requests; the address follows the request inputs every cycle
    always @(posedge ref_clk) begin
        if (rst) begin
            mem_wr_q       <= 1'b0;
            mem_rd_q       <= 1'b0;
            mem_addr_q     <= 24'h00_0000;
            mem_wdata_q    <= 32'h0000_0000;
            mem_byte_en_q  <= 4'h0;
            mem_bit_mask_q <= 8'h00;
        end else begin
            mem_wr_q       <= s2_valid_q & ~s2_read_q;
            mem_rd_q       <= s2_valid_q & s2_read_q;
            mem_addr_q     <= s2_addr_q;
            mem_wdata_q    <= (s2_valid_q & ~s2_read_q) ? wdata_d : 32'h0000_0000;
            mem_byte_en_q  <= s2_valid_q ? byte_en_d : 4'h0;
            mem_bit_mask_q <= s2_valid_q ? bit_mask_d : 8'h00;
        end
    end

    // Read-back decoding of fetched bytes into 32-bit colour
    // Low colour bits of RGB565 and ARGB1555 come back as zero; ARGB4444 nibbles are replicated
    // Decode uses the live format and packing inputs, not the request pipeline
    reg [31:0] argb_d;
    reg [7:0]  sub_d;
    reg [2:0]  dpos_d;

    always @* begin
        dpos_d = fbpp_bit_pos_f(dec_x, dec_y, in_byte_packing_order, pixel_format);
        sub_d  = dec_data[7:0] >> dpos_d;
        argb_d = 32'h0000_0000;
        case (pixel_format)
            `FBPP_FMT_ARGB8888: argb_d = dec_data;
            `FBPP_FMT_RGB888:   argb_d = {`FBPP_OPAQUE, dec_data[23:0]};
            `FBPP_FMT_RGB565: begin
                argb_d = {`FBPP_OPAQUE, dec_data[15:11], 3'b000,
                          dec_data[10:5], 2'b00, dec_data[4:0], 3'b000};
            end
            `FBPP_FMT_ARGB1555: begin
                argb_d = {{8{dec_data[15]}}, dec_data[14:10], 3'b000,
                          dec_data[9:5], 3'b000, dec_data[4:0], 3'b000};
            end
            `FBPP_FMT_ARGB4444: begin
                argb_d = {dec_data[15:12], dec_data[15:12], dec_data[11:8],
                          dec_data[11:8], dec_data[7:4], dec_data[7:4],
                          dec_data[3:0], dec_data[3:0]};
            end
            `FBPP_FMT_GRAY_FOUR_BIT: begin
                argb_d = {`FBPP_OPAQUE,
                          {20'h0_0000, sub_d[3:0]} * `FBPP_REP_FOUR_BIT};
            end
            `FBPP_FMT_GRAY_TWO_BIT: begin
                argb_d = {`FBPP_OPAQUE,
                          {22'h00_0000, sub_d[1:0]} * `FBPP_REP_TWO_BIT};
            end
            default: begin
                argb_d = {`FBPP_OPAQUE,
                          {23'h00_0000, sub_d[0]} * `FBPP_REP_ONE_BIT};
            end
        endcase
    end

    // Decode result register, one cycle behind the fetched data
    always @(posedge ref_clk) begin
        if (rst) begin
            dec_argb_valid_q <= 1'b0;
            dec_argb_q       <= 32'h0000_0000;
        end else begin
            dec_argb_valid_q <= dec_valid;
            dec_argb_q       <= dec_valid ? argb_d : 32'h0000_0000;
        end
    end

endmodule

// [testbench/fbpp_packer_properties.sv]
// Port-level timing and packing checks for the pixel packer
module fbpp_packer_chk (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [2:0]  pixel_format,
    input wire logic        in_byte_packing_order,
    input wire logic        buffer_scan_order,
    input wire logic [10:0] frame_width,
    input wire logic [10:0] frame_height,
    input wire logic        req_valid,
    input wire logic        req_read,
    input wire logic [10:0] req_x,
    input wire logic [10:0] req_y,
    input wire logic [31:0] req_argb,
    input wire logic        mem_wr_q,
    input wire logic        mem_rd_q,
    input wire logic [23:0] mem_addr_q,
    input wire logic [31:0] mem_wdata_q,
    input wire logic [3:0]  mem_byte_en_q,
    input wire logic [7:0]  mem_bit_mask_q,
    input wire logic        dec_valid,
    input wire logic [10:0] dec_x,
    input wire logic [10:0] dec_y,
    input wire logic [31:0] dec_data,
    input wire logic        dec_argb_valid_q,
    input wire logic [31:0] dec_argb_q
);
    // Byte address of a wide pixel, row after row
    function automatic logic [23:0] waddr(input logic [2:0] f, input logic [10:0] x, y, w);
        int b;
        b = (f == 3'h0) ? 4 : (f == 3'h1) ? 3 : 2;
        waddr = 24'((int'(y) * int'(w) + int'(x)) * b);
    endfunction
    // Bit slot of a sub-byte pixel inside its byte
    function automatic logic [7:0] mask_of(input logic [2:0] f, input logic o,
                                           input logic [10:0] x, y);
        int bpp;
        int c;
        bpp = 8 >> (int'(f) - 4);
        c = o ? int'(y) : int'(x);
        mask_of = 8'(((1 << bpp) - 1) << ((c % (8 / bpp)) * bpp));
    endfunction

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_wr_lat; req_valid && !req_read |-> ##3 (mem_wr_q && !mem_rd_q); endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write strobe late");
    property p_rd_lat; req_valid && req_read |->
        ##3 (mem_rd_q && mem_wdata_q == 32'h0000_0000); endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read strobe late");
    property p_addr_wide;
        req_valid && pixel_format <= 3'h4 |-> ##3 mem_addr_q == waddr($past(pixel_format, 3),
            $past(req_x, 3), $past(req_y, 3), $past(frame_width, 3));
    endproperty
    a_addr_wide: assert property (p_addr_wide) else $error("wide pixel address");
    property p_argb; req_valid && !req_read && pixel_format == 3'h0 |->
        ##3 (mem_byte_en_q == 4'hf && mem_wdata_q == $past(req_argb, 3)); endproperty
    a_argb: assert property (p_argb) else $error("32-bit pixel data");
    property p_rgb; req_valid && !req_read && pixel_format == 3'h1 |-> ##3
        (mem_byte_en_q == 4'h7 && mem_wdata_q == {8'h00, 24'($past(req_argb, 3))}); endproperty
    a_rgb: assert property (p_rgb) else $error("24-bit pixel data");
    property p_565; req_valid && !req_read && pixel_format == 3'h2 |-> ##3 (mem_byte_en_q ==
        4'h3 && mem_wdata_q[15:0] == {$past(req_argb[23:19], 3), $past(req_argb[15:10], 3),
        $past(req_argb[7:3], 3)}); endproperty
    a_565: assert property (p_565) else $error("5-6-5 pixel data");
    property p_sub_mask; req_valid && !req_read && pixel_format >= 3'h5 |-> ##3
        (mem_byte_en_q == 4'h1 && mem_bit_mask_q == mask_of($past(pixel_format, 3),
        $past(in_byte_packing_order, 3), $past(req_x, 3), $past(req_y, 3))); endproperty
    a_sub_mask: assert property (p_sub_mask) else $error("sub-byte slot");
    property p_dec_lat; dec_valid |=> dec_argb_valid_q; endproperty
    a_dec_lat: assert property (p_dec_lat) else $error("decode result late");
    property p_dec_gray; dec_valid && pixel_format >= 3'h5 |=> (dec_argb_q[31:24] == 8'hff
        && dec_argb_q[23:16] == dec_argb_q[15:8] && dec_argb_q[7:0] == dec_argb_q[15:8]);
    endproperty
    a_dec_gray: assert property (p_dec_gray) else $error("gray read-back");
endmodule

// [testbench/fbpp_fb_mem.sv]
// Frame buffer memory model on the display side of the packer
module fbpp_fb_mem (
    input  wire logic        ref_clk,
    input  wire logic        mem_wr_q,
    input  wire logic        mem_rd_q,
    input  wire logic [23:0] mem_addr_q,
    input  wire logic [31:0] mem_wdata_q,
    input  wire logic [3:0]  mem_byte_en_q,
    input  wire logic [7:0]  mem_bit_mask_q,
    output logic      [31:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:1023];
    int         k;
    logic [7:0] m;
    initial begin
        for (int i = 0; i < 1024; i++) mem[i] = 8'h00;
    end
    // Lane i lands at address+i; lane0 merges only the masked bits
    always @(posedge ref_clk) begin
        if (mem_wr_q) begin
            for (int i = 0; i < 4; i++) begin
                k = (int'(mem_addr_q) + i) % 1024;
                m = (i == 0) ? mem_bit_mask_q : 8'hff;
                if (mem_byte_en_q[i])
                    mem[k] <= (mem[k] & ~m) | (mem_wdata_q[8*i+:8] & m);
            end
        end
        // Read data is valid one cycle, then scrambled
        if (mem_rd_q) begin
            for (int i = 0; i < 4; i++)
                rd_data[8*i+:8] <= mem[(int'(mem_addr_q) + i) % 1024];
        end else begin
            rd_data <= ~rd_data;
        end
    end
endmodule

// [testbench/tb_frame_buffer_pixel_packer.sv]
// Self-checking bench for the pixel packer with a frame memory model
module tb_frame_buffer_pixel_packer;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, rst, in_byte_packing_order, buffer_scan_order, req_valid, req_read;
    logic        dec_valid, mem_wr_q, mem_rd_q, dec_argb_valid_q;
    logic [2:0]  pixel_format;
    logic [10:0] frame_width, frame_height, req_x, req_y, dec_x, dec_y;
    logic [31:0] req_argb, dec_data, rd_data, mem_wdata_q, dec_argb_q;
    logic [23:0] mem_addr_q;
    logic [3:0]  mem_byte_en_q;
    logic [7:0]  mem_bit_mask_q;
    int          n_mismatch, compares;

    fbpp_packer fbpp_packer_i (.ref_clk(ref_clk), .rst(rst), .pixel_format(pixel_format),
        .in_byte_packing_order(in_byte_packing_order), .buffer_scan_order(buffer_scan_order),
        .frame_width(frame_width), .frame_height(frame_height), .req_valid(req_valid),
        .req_read(req_read), .req_x(req_x), .req_y(req_y), .req_argb(req_argb),
        .mem_wr_q(mem_wr_q), .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q),
        .mem_wdata_q(mem_wdata_q), .mem_byte_en_q(mem_byte_en_q),
        .mem_bit_mask_q(mem_bit_mask_q), .dec_valid(dec_valid), .dec_x(dec_x), .dec_y(dec_y),
        .dec_data(dec_data), .dec_argb_valid_q(dec_argb_valid_q), .dec_argb_q(dec_argb_q));
    fbpp_fb_mem fbpp_fb_mem_i (.ref_clk(ref_clk), .mem_wr_q(mem_wr_q), .mem_rd_q(mem_rd_q),
        .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_byte_en_q(mem_byte_en_q),
        .mem_bit_mask_q(mem_bit_mask_q), .rd_data(rd_data));

    // Comparison with mismatch report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic results;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // One request, then wait for its memory strobe
    task automatic do_req(input logic rd, input logic [10:0] x, y, input logic [31:0] c);
        int n;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_read = rd;
        req_x = x;
        req_y = y;
        req_argb = c;
        @(negedge ref_clk);
        req_valid = 1'b0;
        n = 0;
        while (!(mem_wr_q === 1'b1 || mem_rd_q === 1'b1) && n < 8) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 8) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t no memory strobe", $time);
            results;
        end
    endtask
    // Read a pixel back through memory and the decode port
    task automatic do_back(input logic [10:0] x, y, output logic [31:0] got);
        do_req(1'b1, x, y, 32'h0000_0000);
        @(negedge ref_clk);
        dec_valid = 1'b1;
        dec_x = x;
        dec_y = y;
        dec_data = rd_data;
        @(negedge ref_clk);
        dec_valid = 1'b0;
        got = dec_argb_q;
    endtask
    // Wide formats: address, lanes, encoding and read-back
    task automatic t_wide;
        logic [31:0] c, got, we, de, lm;
        int          b;
        c = 32'h8ac3_5ef1;
        for (int f = 0; f < 5; f++) begin
            pixel_format = 3'(f);
            b = (f == 0) ? 4 : (f == 1) ? 3 : 2;
            lm = (b == 4) ? 32'hffff_ffff : (b == 3) ? 32'h00ff_ffff : 32'h0000_ffff;
            case (f)
                0: {we, de} = {c, c};
                1: {we, de} = {8'h00, c[23:0], 8'hff, c[23:0]};
                2: {we, de} = {16'h0, c[23:19], c[15:10], c[7:3],
                               8'hff, c[23:19], 3'b0, c[15:10], 2'b0, c[7:3], 3'b0};
                3: {we, de} = {16'h0, c[31], c[23:19], c[15:11], c[7:3],
                               {8{c[31]}}, c[23:19], 3'b0, c[15:11], 3'b0, c[7:3], 3'b0};
                default: {we, de} = {16'h0, c[31:28], c[23:20], c[15:12], c[7:4],
                               {2{c[31:28]}}, {2{c[23:20]}}, {2{c[15:12]}}, {2{c[7:4]}}};
            endcase
            do_req(1'b0, 11'd2, 11'd1, c);
            check(mem_addr_q, 24'((10 + 2) * b), "wide address");
            check(mem_byte_en_q, 4'(lm[3:0] & 4'hf) & 4'((1 << b) - 1), "lanes");
            check(mem_wdata_q, we, "encoded pixel");
            do_back(11'd2, 11'd1, got);
            check(fbpp_fb_mem_i.mem[24 * b / 2] | 32'h0, we[7:0], "lowest byte first");
            check(got, de, "decoded colour");
        end
        $display("t_wide done");
    endtask
    // Gray formats over every packing and scan order
    task automatic t_gray;
        logic [31:0] c, got;
        logic [7:0]  code;
        int          s, bpp, ppb, a, sl, sl2, w, h;
        w = 10;
        h = 7;
        for (int f = 5; f < 8; f++) for (int o = 0; o < 2; o++) for (int sc = 0; sc < 2; sc++) begin
            pixel_format = 3'(f);
            in_byte_packing_order = 1'(o);
            buffer_scan_order = 1'(sc);
            s = f - 4;
            bpp = 8 >> s;
            ppb = 1 << s;
            c = (f == 7) ? 32'h12ff_ffff : 32'h12aa_aaaa;
            code = c[7:0] / ((f == 5) ? 8'h11 : (f == 6) ? 8'h55 : 8'hff);
            if (sc == 0) a = (o == 0) ? 3 * ((w + ppb - 1) / ppb) + (5 >> s) : (3 >> s) * w + 5;
            else a = (o == 0) ? (5 >> s) * h + 3 : 5 * ((h + ppb - 1) / ppb) + (3 >> s);
            sl = ((o == 0) ? 5 : 3) % ppb;
            sl2 = ((o == 0) ? 4 : 2) % ppb;
            do_req(1'b0, 11'd5, 11'd3, c);
            check(mem_addr_q, 24'(a), "packed address");
            check(mem_wdata_q[7:0], 8'(code << (sl * bpp)), "gray code");
            do_req(1'b0, (o == 0) ? 11'd4 : 11'd5, (o == 0) ? 11'd3 : 11'd2, 32'h0000_0000);
            check(mem_addr_q, 24'(a), "shared byte");
            do_back(11'd5, 11'd3, got);
            check(fbpp_fb_mem_i.mem[a] & 8'(((1 << bpp) - 1) << (sl * bpp) | ((1 << bpp) - 1)
                  << (sl2 * bpp)), 8'(code << (sl * bpp)), "merged byte");
            check(got, 32'hff00_0000 | code * ((f == 5) ? 32'h0011_1111 : (f == 6) ?
                  32'h0055_5555 : 32'h00ff_ffff), "gray read-back");
        end
        $display("t_gray done");
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (50000) @(posedge ref_clk);
        n_mismatch++;
        results;
    end
    initial begin
        rst = 1'b1;
        {req_valid, req_read, dec_valid, in_byte_packing_order, buffer_scan_order} = 5'h00;
        {pixel_format, req_x, req_y, dec_x, dec_y, req_argb, dec_data} = '0;
        frame_width = 11'd10;
        frame_height = 11'd7;
        n_mismatch = 0;
        compares = 0;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        t_wide;
        t_gray;
        results;
    end
endmodule

bind fbpp_packer fbpp_packer_chk fbpp_packer_chk_i (.ref_clk(ref_clk), .rst(rst),
    .pixel_format(pixel_format), .in_byte_packing_order(in_byte_packing_order),
    .buffer_scan_order(buffer_scan_order), .frame_width(frame_width),
    .frame_height(frame_height), .req_valid(req_valid), .req_read(req_read), .req_x(req_x),
    .req_y(req_y), .req_argb(req_argb), .mem_wr_q(mem_wr_q), .mem_rd_q(mem_rd_q),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_byte_en_q(mem_byte_en_q),
    .mem_bit_mask_q(mem_bit_mask_q), .dec_valid(dec_valid), .dec_x(dec_x), .dec_y(dec_y),
    .dec_data(dec_data), .dec_argb_valid_q(dec_argb_valid_q), .dec_argb_q(dec_argb_q));
